// file: urs_status_reporter.sv
// Status byte reporter of a ULPI transceiver with an AXI4-Lite control port.
`timescale 1ns/1ps
`include "urs_params.svh"
module urs_status_reporter
  import urs_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ULPI bus.
  input  wire logic        stp,
  input  wire logic [7:0]  dataIn,
  output      logic [7:0]  dataOut,
  output      logic        dataOe,
  output      logic        dir,
  output      logic        nxt,
  // Line and comparator levels.
  input  wire logic        dpSe,
  input  wire logic        dmSe,
  input  wire logic        squelch,
  input  wire logic        hsDiffRx,
  input  wire logic        session_end_level,
  input  wire logic        session_valid_level,
  input  wire logic        vbus_valid_level,
  input  wire logic        idPin,
  input  wire logic        altIntLatched,
  // Receiver.
  input  wire logic        rxActive,
  input  wire logic        rxError,
  input  wire logic        rxByteValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        host_disconnect_event,
  // Mode sequencing.
  input  wire logic        startupDone,
  input  wire logic        asyncExit,
  // AXI4-Lite slave.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready
);

  typedef struct packed {
    urs_state_type  st;
    logic           dir;
    logic           nxt;
    logic [7:0]     dataOut;
    logic           dataOe;
    logic           pending;
    logic           exitPend;
    logic           discFlag;
    logic           linkTx;
    logic           stpPrev;
    logic           ctrlEn;
    urs_speed_type  speed;
    logic [7:0]     lastCmd;
    logic [CNT_W-1:0] count;
    logic           awHeld;
    logic [7:0]     awAddr;
    logic           wHeld;
    logic [31:0]    wData;
    logic [3:0]     wStrb;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } urs_state_all_type;

  urs_state_all_type s;
  urs_state_all_type next_s;

  logic [1:0] lineNow;
  logic [1:0] vbusNow;
  logic [1:0] evtNow;
  logic [7:0] cmdByte;
  logic       lineChg;
  logic       otgChg;
  logic       busIdle;

  always_comb begin
    case (s.speed)
      URS_SPD_HS: begin
        lineNow = squelch ? `URS_LS_SE0 : `URS_LS_J;
      end
      URS_SPD_CHIRP: begin
        lineNow = squelch ? `URS_LS_SE0 : (hsDiffRx ? `URS_LS_J : `URS_LS_K);
      end
      default: begin
        lineNow = {dmSe, dpSe};
      end
    endcase
  end

  always_comb begin
    if (vbus_valid_level) begin
      vbusNow = `URS_VBUS_ABOVE;
    end else if (session_valid_level) begin
      vbusNow = `URS_VBUS_VALIDSES;
    end else if (session_end_level) begin
      vbusNow = `URS_VBUS_LOW;
    end else begin
      vbusNow = `URS_VBUS_SESS;
    end
  end

  always_comb begin
    if (s.discFlag) begin
      evtNow = `URS_EVT_DISC;
    end else if (rxActive && rxError) begin
      evtNow = `URS_EVT_ERROR;
    end else if (rxActive) begin
      evtNow = `URS_EVT_ACTIVE;
    end else begin
      evtNow = `URS_EVT_NONE;
    end
  end

  assign cmdByte = {altIntLatched, idPin, evtNow, vbusNow, lineNow};

  urs_change_detect #(.W(2)) lineWatch (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   (lineNow),
    .changed (lineChg)
  );

  // Comparator watch.
  // Raw comparator outputs are watched, so a change that keeps the VBUS code still reports.
  urs_change_detect #(.W(5)) otgWatch (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   ({altIntLatched, idPin, vbus_valid_level, session_valid_level, session_end_level}),
    .changed (otgChg)
  );

  assign busIdle = !s.dir && !stp && (dataIn == 8'h00) && !s.linkTx;

  always_comb begin
    logic emit;
    logic want;
    logic wrDo;
    logic [7:0] rdA;
    emit   = 1'b0;
    want   = (s.pending && s.ctrlEn) || s.exitPend;
    wrDo   = 1'b0;
    rdA    = 8'h00;
    next_s = s;
    next_s.stpPrev = stp;

    // Link transmit tracking.
    if (!s.dir && (s.st == URS_ST_IDLE) && (dataIn[7:6] == `URS_TXCMD_XMIT)) begin
      next_s.linkTx = 1'b1;
    end else if (s.linkTx) begin
      if (s.speed == URS_SPD_HS) begin
        if (s.stpPrev && !stp) begin
          next_s.linkTx = 1'b0;
        end
      end else if (stp) begin
        next_s.linkTx = 1'b0;
      end
    end

    case (s.st)
      URS_ST_STARTUP: begin
        if (startupDone) begin
          next_s.dir      = 1'b0;
          next_s.exitPend = 1'b1;
          next_s.st       = URS_ST_TURN_OFF;
        end
      end
      URS_ST_IDLE: begin
        next_s.nxt    = 1'b0;
        next_s.dataOe = 1'b0;
        if (rxActive && busIdle) begin
          next_s.dir = 1'b1;
          next_s.nxt = 1'b1;
          next_s.st  = URS_ST_RX_TURN;
        end else if (want && busIdle) begin
          next_s.dir = 1'b1;
          next_s.st  = URS_ST_TURN_ON;
        end
      end
      URS_ST_TURN_ON: begin
        next_s.nxt    = 1'b0;
        next_s.dataOe = 1'b1;
        next_s.st     = URS_ST_SEND;
        emit          = 1'b1;
      end
      URS_ST_RX_TURN: begin
        next_s.dataOe = 1'b1;
        next_s.st     = URS_ST_RECV;
        next_s.nxt    = rxByteValid;
        emit          = !rxByteValid;
        next_s.dataOut = rxByte;
      end
      URS_ST_SEND: begin
        if (rxActive) begin
          next_s.st      = URS_ST_RECV;
          next_s.nxt     = rxByteValid;
          emit           = !rxByteValid;
          next_s.dataOut = rxByte;
        end else if ((lineChg || otgChg || s.pending) && s.ctrlEn) begin
          emit = 1'b1;
        end else begin
          next_s.dir    = 1'b0;
          next_s.dataOe = 1'b0;
          next_s.st     = URS_ST_TURN_OFF;
        end
      end
      URS_ST_RECV: begin
        next_s.nxt     = rxByteValid;
        emit           = !rxByteValid;
        next_s.dataOut = rxByte;
        if (!rxActive && !rxByteValid) begin
          next_s.st = URS_ST_SEND;
        end
      end
      URS_ST_TURN_OFF: begin
        next_s.st = URS_ST_IDLE;
      end
      default: begin
        next_s.st = URS_ST_IDLE;
      end
    endcase

    if (emit) begin
      next_s.dataOut  = cmdByte;
      next_s.lastCmd  = cmdByte;
      next_s.count    = s.count + 1'b1;
      next_s.pending  = 1'b0;
      next_s.exitPend = 1'b0;
      next_s.discFlag = 1'b0;
    end

    // Line and comparator changes do not set pending in a sending cycle; disconnect and exit events win over the clear.
    if ((lineChg || otgChg) && s.ctrlEn && !emit) begin
      next_s.pending = 1'b1;
    end
    if (host_disconnect_event) begin
      next_s.discFlag = 1'b1;
      if (s.ctrlEn) begin
        next_s.pending = 1'b1;
      end
    end
    if (asyncExit) begin
      next_s.exitPend = 1'b1;
    end

    // AXI4-Lite write channel.
    if (awvalid && s.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.awHeld && next_s.wHeld && !s.bvalid) begin
      wrDo          = 1'b1;
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `URS_RESP_OKAY;
    end
    if (wrDo) begin
      if (next_s.awAddr == `URS_OFF_CTRL) begin
        if (next_s.wStrb[0]) begin
          next_s.ctrlEn = next_s.wData[`URS_CTRL_EN_BIT];
          next_s.speed  = urs_speed_type'(next_s.wData[`URS_CTRL_SPD_MSB:`URS_CTRL_SPD_LSB]);
        end
      end else if ((next_s.awAddr != `URS_OFF_STATUS) && (next_s.awAddr != `URS_OFF_COUNT)) begin
        next_s.bresp = `URS_RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.awHeld && !next_s.bvalid;
    next_s.wready  = !next_s.wHeld && !next_s.bvalid;

    // AXI4-Lite read channel.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      rdA           = araddr;
      next_s.rvalid = 1'b1;
      next_s.rresp  = `URS_RESP_OKAY;
      next_s.rdata  = 32'h00000000;
      case (rdA)
        `URS_OFF_CTRL: begin
          next_s.rdata[`URS_CTRL_EN_BIT] = s.ctrlEn;
          next_s.rdata[`URS_CTRL_SPD_MSB:`URS_CTRL_SPD_LSB] = s.speed;
        end
        `URS_OFF_STATUS: begin
          next_s.rdata[7:0]                = s.lastCmd;
          next_s.rdata[`URS_STAT_PEND_BIT] = s.pending;
          next_s.rdata[`URS_STAT_DIR_BIT]  = s.dir;
          next_s.rdata[`URS_STAT_TX_BIT]   = s.linkTx;
        end
        `URS_OFF_COUNT: begin
          next_s.rdata[CNT_W-1:0] = s.count;
        end
        default: begin
          next_s.rresp = `URS_RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.st      <= URS_ST_STARTUP;
      s.dir     <= 1'b1;
      s.ctrlEn  <= `URS_CTRL_EN_RST;
      s.speed   <= urs_speed_type'(`URS_CTRL_SPD_RST);
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign dataOut = s.dataOut;
  assign dataOe  = s.dataOe;
  assign dir     = s.dir;
  assign nxt     = s.nxt;
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

endmodule : urs_status_reporter

// file: urs_params.svh
// Register offsets, field positions, reset values and encodings of the status reporter.
`ifndef URS_PARAMS_SVH
`define URS_PARAMS_SVH

`define URS_OFF_CTRL      8'h00
`define URS_OFF_STATUS    8'h04
`define URS_OFF_COUNT     8'h08

`define URS_CTRL_EN_BIT   0
`define URS_CTRL_SPD_LSB  1
`define URS_CTRL_SPD_MSB  2
`define URS_CTRL_EN_RST   1'h1
`define URS_CTRL_SPD_RST  2'h0

`define URS_STAT_PEND_BIT 8
`define URS_STAT_DIR_BIT  9
`define URS_STAT_TX_BIT   10

`define URS_RESP_OKAY     2'h0
`define URS_RESP_SLVERR   2'h2

`define URS_TXCMD_XMIT    2'h1
`define URS_VBUS_LOW      2'h0
`define URS_VBUS_SESS     2'h1
`define URS_VBUS_VALIDSES 2'h2
`define URS_VBUS_ABOVE    2'h3
`define URS_EVT_NONE      2'h0
`define URS_EVT_ACTIVE    2'h1
`define URS_EVT_ERROR     2'h3
`define URS_EVT_DISC      2'h2
`define URS_LS_SE0        2'h0
`define URS_LS_J          2'h1
`define URS_LS_K          2'h2

`endif

// file: urs_pkg.sv
// Types shared by the status reporter modules.
package urs_pkg;

  typedef enum logic [1:0] {
    URS_SPD_FSLS,
    URS_SPD_HS,
    URS_SPD_CHIRP
  } urs_speed_type;

  typedef enum logic [2:0] {
    URS_ST_STARTUP,
    URS_ST_IDLE,
    URS_ST_TURN_ON,
    URS_ST_RX_TURN,
    URS_ST_SEND,
    URS_ST_RECV,
    URS_ST_TURN_OFF
  } urs_state_type;

endpackage : urs_pkg

// file: urs_change_detect.sv
// Flags any change of a sampled level against its value one cycle earlier.
`timescale 1ns/1ps
module urs_change_detect
  import urs_pkg::*;
#(
  parameter int W = 2
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Watched level and change flag.
  input  wire logic [W-1:0] level,
  output      logic         changed
);

  typedef struct packed {
    logic [W-1:0] prev;
  } urs_chg_state_type;

  urs_chg_state_type s;
  urs_chg_state_type next_s;

  always_comb begin
    next_s      = s;
    next_s.prev = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign changed = (level != s.prev);

endmodule : urs_change_detect

// file: urs_status_reporter_properties.sv
// Port-level timing and field checks of the status reporter.
`timescale 1ns/1ps
module urs_status_reporter_properties
  import urs_pkg::*;
(
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_n,
  // Bus and levels.
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic       dataOe,
  input wire logic [7:0] dataOut,
  input wire logic [7:0] rxByte,
  input wire logic       idPin,
  input wire logic       altIntLatched,
  input wire logic       vbus_valid_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_turn_rise: assert property ($rose(dir) |-> !dataOe)
    else $error("bus driven in turnaround after dir rise");
  a_turn_fall: assert property ($fell(dir) |-> !dataOe)
    else $error("bus driven after dir fall");
  a_drive_own: assert property (dataOe |-> dir)
    else $error("bus driven without dir");
  a_byte_turn: assert property ($rose(dir) && !nxt |-> !dataOe ##1 (dataOe && !nxt))
    else $error("status byte not after turnaround");
  a_id_bit: assert property (dataOe && !nxt |-> dataOut[6] == $past(idPin))
    else $error("id bit wrong");
  a_alt_bit: assert property (dataOe && !nxt |-> dataOut[7] == $past(altIntLatched))
    else $error("alternate interrupt bit wrong");
  a_vbus_top: assert property (dataOe && !nxt && $past(vbus_valid_level)
    |-> dataOut[3:2] == 2'h3)
    else $error("vbus code wrong");
  a_rx_data: assert property (dataOe && nxt |-> dataOut == $past(rxByte))
    else $error("receive data wrong");

  c_status: cover property ($rose(dir) && !nxt);
  c_receive: cover property ($rose(dir) && nxt);
  c_back: cover property (dataOe && !nxt ##1 dataOe && !nxt);
endmodule : urs_status_reporter_properties

bind urs_status_reporter urs_status_reporter_properties u_urs_status_reporter_properties (
  .clk, .rst_n, .dir, .nxt, .dataOe, .dataOut, .rxByte, .idPin, .altIntLatched,
  .vbus_valid_level);

// file: urs_link_model.sv
// Link controller model driving STP and the link side of the data bus.
`timescale 1ns/1ps
module urs_link_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ULPI bus.
  input  wire logic        dir,
  input  wire logic        nxt,
  input  wire logic        dataOe,
  input  wire logic [7:0]  dataOut,
  output      logic        stp,
  output      logic [7:0]  dataIn,
  // Bench control and latch reads owed.
  input  wire logic        txGo,
  output      logic [15:0] latchReads
);
  logic       dirQ;
  logic [3:0] txCnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dirQ   <= 1'b1;
      txCnt  <= 4'h0;
      stp    <= 1'b0;
      dataIn <= 8'h00;
      latchReads <= 16'h0000;
    end else begin
      dirQ <= dir;
      // alt_int seen: a carkit latch read is owed
      if (dataOe && !nxt && dataOut[7]) begin
        latchReads <= latchReads + 16'h0001;
      end
      stp <= (txCnt == 4'h2);
      if (txCnt != 4'h0) begin
        txCnt <= txCnt - 4'h1;
      end else if (txGo && !dir) begin
        txCnt <= 4'h8;
      end
      if (dir || dirQ) begin
        dataIn <= ~dataIn;
      end else begin
        dataIn <= (txCnt == 4'h8) ? 8'h40 : ((txCnt > 4'h2) ? 8'h5A : 8'h00);
      end
    end
  end
endmodule : urs_link_model

// file: tb.sv
// Self-checking bench of the status reporter with a link model.
`timescale 1ns/1ps
module tb;
  import urs_pkg::*;
  logic        clk, rst_n, stp, dataOe, dir, nxt, seen;
  logic        rxActive, rxError, rxByteValid, startupDone, asyncExit, txGo;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        hostDisc, discExp;
  logic [7:0]  lastSt;
  logic [15:0] latchReads;
  int          sent = 0;
  int          altSent = 0;
  logic [1:0]  bresp, rresp, r, spd;
  logic [3:0]  wstrb;
  logic [7:0]  dataIn, dataOut, rxByte, rxPrev, expByte, awaddr, araddr;
  logic [8:0]  lv;
  logic [31:0] wdata, rdata, d;
  int          seed = 32'hF1BC;
  int          fails = 0;
  int          checks_done = 0;

  urs_status_reporter u_urs_status_reporter (
    .clk, .rst_n, .stp, .dataIn, .dataOut, .dataOe, .dir, .nxt,
    .dpSe(lv[0]), .dmSe(lv[1]), .squelch(lv[2]), .session_end_level(lv[3]),
    .session_valid_level(lv[4]), .vbus_valid_level(lv[5]), .idPin(lv[6]),
    .hsDiffRx(lv[7]), .altIntLatched(lv[8]), .rxActive, .rxError, .rxByteValid,
    .rxByte, .host_disconnect_event(hostDisc), .startupDone, .asyncExit,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  urs_link_model u_urs_link_model (.clk, .rst_n, .dir, .nxt, .dataOe, .dataOut, .stp, .dataIn,
    .txGo, .latchReads);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  function automatic logic [7:0] calc();
    logic [1:0] ln;
    logic [1:0] vb;
    ln = (spd == 2'h0) ? lv[1:0] : (lv[2] ? 2'h0 : ((spd == 2'h1 || lv[7]) ? 2'h1 : 2'h2));
    vb = lv[5] ? 2'h3 : (lv[4] ? 2'h2 : (lv[3] ? 2'h0 : 2'h1));
    return {lv[8], lv[6], (discExp ? 2'h2 : {rxActive & rxError, rxActive}), vb, ln};
  endfunction : calc

  function automatic logic rel(input int i);
    return (i > 2 && i < 7) || (spd == 2'h0 ? i < 2 : (i == 2 || (i == 7 && spd == 2'h2)));
  endfunction : rel

  always @(posedge clk) begin
    if (rst_n && dataOe === 1'b1) cmp("busByte", {24'h0, nxt ? rxPrev : expByte}, {24'h0, dataOut});
    if (rst_n && dataOe === 1'b1 && nxt === 1'b0) begin
      sent    <= sent + 1;
      altSent <= altSent + {31'h0, dataOut[7]};
      lastSt  <= dataOut;
      discExp <= 1'b0;
    end
    if (hostDisc) discExp <= 1'b1;
    expByte <= calc();
    rxPrev  <= rxByte;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic watch(input logic e);
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (dataOe === 1'b1) seen = 1'b1;
    end
    cmp("byteSent", {31'h0, e}, {31'h0, seen});
  endtask : watch

  task automatic hit(input int i, input logic e);
    lv[i] <= ~lv[i];
    watch(e);
  endtask : hit

  initial begin
    {rst_n, rxActive, rxError, rxByteValid, startupDone, asyncExit, txGo} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {rxByte, lv, spd, hostDisc, discExp} = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp("dirAtStart", 32'h1, {31'h0, dir});
    startupDone <= 1'b1;
    watch(1'b1);
    startupDone <= 1'b0;
    rd(8'h00);
    cmp("ctrlReset", 32'h1, d);
    rd(8'h0C);
    cmp("rdUnmapped", 32'h2, {30'h0, r});
    cmp("rdUnmappedData", 32'h0, d);
    wr(8'h10, 32'h0);
    cmp("wrUnmapped", 32'h2, {30'h0, r});
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, {29'h0, 2'(s), 1'b1});
      spd = 2'(s);
      lv <= 9'h000;
      repeat (12) @(posedge clk);
      for (int i = 7; i >= 0; i--) if (rel(i)) hit(i, 1'b1);
    end
    repeat (40) begin
      lv <= 9'($random(seed));
      repeat (1 + ($random(seed) & 3)) @(posedge clk);
    end
    repeat (12) @(posedge clk);
    rxActive <= 1'b1;
    repeat (10) begin
      @(posedge clk);
      rxByteValid <= 1'($random(seed));
      rxByte      <= 8'($random(seed));
      rxError     <= 1'($random(seed));
    end
    @(posedge clk);
    {rxActive, rxByteValid, rxError} <= 3'h0;
    repeat (10) @(posedge clk);
    cmp("dirAfterRx", 32'h0, {31'h0, dir});
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, {29'h0, 2'(s), 1'b1});
      spd = 2'(s);
      repeat (12) @(posedge clk);
      txGo <= 1'b1;
      @(posedge clk);
      txGo <= 1'b0;
      repeat (3) @(posedge clk);
      lv[6] <= ~lv[6];
      seen = 1'b0;
      while (stp !== 1'b1) begin
        @(posedge clk);
        if (dir !== 1'b0) seen = 1'b1;
      end
      cmp("dirInTx", 32'h0, {31'h0, seen});
      watch(1'b1);
    end
    hostDisc <= 1'b1;
    @(posedge clk);
    hostDisc <= 1'b0;
    watch(1'b1);
    wr(8'h00, 32'h0);
    spd = 2'h0;
    hit(6, 1'b0);
    asyncExit <= 1'b1;
    @(posedge clk);
    asyncExit <= 1'b0;
    watch(1'b1);
    rd(8'h08);
    cmp("countReg", sent, d);
    rd(8'h04);
    cmp("statusReg", {24'h0, lastSt}, d);
    cmp("latchReads", altSent, {16'h0, latchReads});
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : tb
